/* File: hw/ffps_regs.svh */
// constants for the fast program sequencer of a parallel nor flash
// Functional notes
// - host keeps accel off for double, quadruple, octuple page program
// - host issues read/reset after a program error
// - double program: setup plus two pairs differing in lowest bit
// - quadruple program: setup plus four pairs differing in two low bits
// - octuple program byte mode only: setup plus eight pairs, three bits
// - buffered program opens with two unlocks then setup at block
// - fourth write gives count N for N+1 locations, abort if too big
// - fifth write first pair, further loads follow start address
// - all loads inside one 256 word page, crossing aborts
// - host ends loads with buffer program confirm command
// - after abort host writes abort-and-reset sequence, reset after fail
`ifndef FFPS_REGS_SVH
`define FFPS_REGS_SVH
`define FFPS_CLK_NS 20
`define FFPS_T_WE_LOW_NS 35
`define FFPS_T_WE_HIGH_NS 30
`define FFPS_T_READ_NS 70
`define FFPS_CYC(ns) (((ns) + `FFPS_CLK_NS - 1) / `FFPS_CLK_NS)
`define FFPS_WE_LOW_CYC 4'(`FFPS_CYC(`FFPS_T_WE_LOW_NS))
`define FFPS_WE_HIGH_CYC 4'(`FFPS_CYC(`FFPS_T_WE_HIGH_NS))
`define FFPS_READ_CYC 4'(`FFPS_CYC(`FFPS_T_READ_NS))
`define FFPS_UNLK1_X16 24'h000555
`define FFPS_UNLK2_X16 24'h0002aa
`define FFPS_UNLK1_X8 24'h000aaa
`define FFPS_UNLK2_X8 24'h000555
`define FFPS_CODE_UNLK1 8'haa
`define FFPS_CODE_UNLK2 8'h55
`define FFPS_CODE_RESET 8'hf0
`define FFPS_CODE_SUSPEND 8'hb0
`define FFPS_CODE_RESUME 8'h30
`define FFPS_PAGE_LIM_WORD 10'h0ff
`define FFPS_PAGE_LIM_BYTE 10'h1ff
`define FFPS_ABORT_BIT 1
`define FFPS_ERROR_BIT 5
`define FFPS_POLL_BIT 7
`define FFPS_GRP_DBL_MSK 24'h000001
`define FFPS_GRP_QUAD_MSK 24'h000003
`define FFPS_GRP_OCT_MSK 24'h000007
`define FFPS_GRP_DBL_LAST 10'd2
`define FFPS_GRP_QUAD_LAST 10'd4
`define FFPS_GRP_OCT_LAST 10'd8
`define FFPS_BUF_LOAD0 10'd4
`define FFPS_BUF_OVERHEAD 10'd5
`define FFPS_ABR_LAST 10'd2
`endif

/* File: hw/ffps_pkg.sv */
// types for the fast program sequencer
package ffps_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_RST, OP_ABR, OP_DBL, OP_QUAD, OP_OCT, OP_BUF
  } ffps_op_t;
  typedef enum logic [1:0] {
    RES_OK, RES_FAIL, RES_ABORT, RES_REFUSED
  } ffps_res_t;
  typedef enum logic [1:0] {SP_NONE, SP_SUSP, SP_RES} ffps_sp_t;
  typedef struct packed {
    ffps_op_t op;
    logic [23:0] addr;
    logic [7:0] count;
  } ffps_cmd_t;
  typedef struct packed {
    logic [22:0] a;
    logic [15:0] dq;
    logic [15:0] dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } ffps_pins_t;
endpackage

/* File: hw/ffps_ctrl.sv */
// host controller driving the flash fast program command sequences
`timescale 1ns/100ps
`default_nettype none
`include "ffps_regs.svh"
module ffps_ctrl import ffps_pkg::*; #(
  parameter logic [7:0] DBL_SETUP = 8'h01,
  parameter logic [7:0] QUAD_SETUP = 8'h02,
  parameter logic [7:0] OCT_SETUP = 8'h03,
  parameter logic [7:0] BUF_SETUP = 8'h04,
  parameter logic [7:0] BUF_CONFIRM = 8'h05,
  parameter logic [7:0] ABORT_RESET = 8'hf0
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CMD_VALID_I,
  input wire ffps_cmd_t CMD_I,
  input wire logic BYTE_MODE_I,
  input wire logic ACCEL_I,
  input wire logic SUSPEND_I,
  input wire logic WDATA_VALID_I,
  input wire logic [15:0] WDATA_I,
  input wire logic [15:0] FL_DQ_I,
  output logic CMD_READY_O,
  output logic WDATA_ACK_O,
  output logic DONE_O,
  output ffps_res_t RESULT_O,
  output logic [15:0] RDATA_O,
  output logic SUSPENDED_O,
  output logic [22:0] FL_A_O,
  output logic [15:0] FL_DQ_O,
  output logic [15:0] FL_DQ_OE_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  output logic FL_BYTE_N_O,
  output logic FL_ACCEL_O
);
  typedef enum {
    ST_IDLE, ST_WSET, ST_WADR, ST_WLOW, ST_WHIGH, ST_RLOW, ST_EVAL,
    ST_SUSP, ST_DONE
  } ffps_st_t;

  ffps_st_t state;
  ffps_op_t op;
  ffps_sp_t special;
  ffps_pins_t pins;
  logic [23:0] base;
  logic [7:0] cnt;
  logic [9:0] step;
  logic [9:0] last;
  logic [3:0] tmr;
  logic [15:0] rd;
  logic exp7;
  logic second;
  logic byte_mode;
  logic [23:0] cur_addr;
  logic [15:0] cur_data;
  logic cur_load;
  logic [23:0] u1;
  logic [23:0] u2;
  logic [23:0] gmsk;
  logic [9:0] page_end;
  logic refuse;

  // ---------------------------------------------------------------
  // address and data of the current bus write
  // ---------------------------------------------------------------
  always_comb begin
    u1 = byte_mode ? `FFPS_UNLK1_X8 : `FFPS_UNLK1_X16;
    u2 = byte_mode ? `FFPS_UNLK2_X8 : `FFPS_UNLK2_X16;
    gmsk = (op == OP_DBL) ? `FFPS_GRP_DBL_MSK :
           (op == OP_QUAD) ? `FFPS_GRP_QUAD_MSK : `FFPS_GRP_OCT_MSK;
    cur_addr = base;
    cur_data = 16'h0000;
    cur_load = 1'b0;
    unique case (op)
      OP_BUF: begin
        if (step == 10'd0) begin
          cur_addr = u1;
          cur_data = {8'h00, `FFPS_CODE_UNLK1};
        end else if (step == 10'd1) begin
          cur_addr = u2;
          cur_data = {8'h00, `FFPS_CODE_UNLK2};
        end else if (step == 10'd2) begin
          cur_data = {8'h00, BUF_SETUP};
        end else if (step == 10'd3) begin
          cur_data = {8'h00, cnt};
        end else if (step == last) begin
          cur_data = {8'h00, BUF_CONFIRM};
        end else begin
          // sequential from the start, never past the page end
          cur_addr = base + {14'h0000, step - `FFPS_BUF_LOAD0};
          cur_data = WDATA_I;
          cur_load = 1'b1;
        end
      end
      OP_DBL, OP_QUAD, OP_OCT: begin
        if (step == 10'd0) begin
          cur_data = {8'h00, (op == OP_DBL) ? DBL_SETUP :
                      (op == OP_QUAD) ? QUAD_SETUP : OCT_SETUP};
        end else begin
          // only the low bits of the page vary
          cur_addr = (base & ~gmsk) | ({14'h0000, step - 10'd1} & gmsk);
          cur_data = WDATA_I;
          cur_load = 1'b1;
        end
      end
      OP_ABR: begin
        if (step == 10'd0) begin
          cur_addr = u1;
          cur_data = {8'h00, `FFPS_CODE_UNLK1};
        end else if (step == 10'd1) begin
          cur_addr = u2;
          cur_data = {8'h00, `FFPS_CODE_UNLK2};
        end else begin
          cur_data = {8'h00, ABORT_RESET};
        end
      end
      OP_RST: cur_data = {8'h00, `FFPS_CODE_RESET};
      OP_READ: cur_data = 16'h0000;
    endcase
    if (special == SP_SUSP) begin
      cur_data = {8'h00, `FFPS_CODE_SUSPEND};
      cur_load = 1'b0;
    end else if (special == SP_RES) begin
      cur_data = {8'h00, `FFPS_CODE_RESUME};
      cur_load = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request screening
  // ---------------------------------------------------------------
  // a load run crossing its page would only earn an abort, so it is refused
  always_comb begin
    page_end = BYTE_MODE_I ? {1'b0, CMD_I.addr[8:0]} :
               {2'b00, CMD_I.addr[7:0]};
    page_end = page_end + {2'b00, CMD_I.count};
    refuse = 1'b0;
    if (CMD_I.op == OP_OCT && !BYTE_MODE_I) begin
      refuse = 1'b1;
    end
    if (CMD_I.op == OP_BUF && page_end > (BYTE_MODE_I ?
        `FFPS_PAGE_LIM_BYTE : `FFPS_PAGE_LIM_WORD)) begin
      refuse = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // width select and acceleration pin
  // ---------------------------------------------------------------
  // accel only with buffered program; never in read mode, which would
  // drop the flash into unlock bypass behind our back
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      byte_mode <= 1'b0;
      FL_BYTE_N_O <= 1'b1;
      FL_ACCEL_O <= 1'b0;
    end else if (state == ST_IDLE && CMD_VALID_I && CMD_READY_O &&
        !refuse) begin
      byte_mode <= BYTE_MODE_I;
      FL_BYTE_N_O <= !BYTE_MODE_I;
      FL_ACCEL_O <= ACCEL_I && CMD_I.op == OP_BUF;
    end else if (state == ST_DONE) begin
      FL_ACCEL_O <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= ST_IDLE;
      op <= OP_READ;
      special <= SP_NONE;
      base <= 24'h000000;
      cnt <= 8'h00;
      step <= 10'd0;
      last <= 10'd0;
      tmr <= 4'h0;
      rd <= 16'h0000;
      exp7 <= 1'b0;
      second <= 1'b0;
      pins <= '{a: 23'h000000, dq: 16'h0000, dq_oe: 16'h0000,
                ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      CMD_READY_O <= 1'b0;
      WDATA_ACK_O <= 1'b0;
      DONE_O <= 1'b0;
      RESULT_O <= RES_OK;
      RDATA_O <= 16'h0000;
      SUSPENDED_O <= 1'b0;
    end else begin
      WDATA_ACK_O <= 1'b0;
      DONE_O <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          CMD_READY_O <= 1'b1;
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 16'h0000;
          // only a ready-qualified offer is a take, else one is taken twice
          if (CMD_VALID_I && CMD_READY_O) begin
            CMD_READY_O <= 1'b0;
            op <= CMD_I.op;
            base <= CMD_I.addr;
            cnt <= CMD_I.count;
            step <= 10'd0;
            second <= 1'b0;
            RESULT_O <= RES_OK;
            unique case (CMD_I.op)
              OP_BUF: last <= {2'b00, CMD_I.count} + `FFPS_BUF_OVERHEAD;
              OP_DBL: last <= `FFPS_GRP_DBL_LAST;
              OP_QUAD: last <= `FFPS_GRP_QUAD_LAST;
              OP_OCT: last <= `FFPS_GRP_OCT_LAST;
              OP_ABR: last <= `FFPS_ABR_LAST;
              OP_RST, OP_READ: last <= 10'd0;
            endcase
            if (refuse) begin
              RESULT_O <= RES_REFUSED;
              state <= ST_DONE;
            end else if (CMD_I.op == OP_READ) begin
              state <= ST_RLOW;
              tmr <= `FFPS_READ_CYC;
            end else begin
              state <= ST_WSET;
            end
          end
        end
        ST_WSET: begin
          // a load waits here for its data: back-pressure on the stream
          if (!cur_load || WDATA_VALID_I) begin
            pins.a <= byte_mode ? cur_addr[23:1] : cur_addr[22:0];
            pins.dq <= byte_mode ? {cur_addr[0], 7'h00, cur_data[7:0]} :
                       cur_data;
            pins.dq_oe <= 16'hffff;
            pins.ce_n <= 1'b0;
            pins.oe_n <= 1'b1;
            if (cur_load) begin
              WDATA_ACK_O <= 1'b1;
              exp7 <= cur_data[`FFPS_POLL_BIT];
            end
            state <= ST_WADR;
          end
        end
        ST_WADR: begin
          pins.we_n <= 1'b0;
          tmr <= `FFPS_WE_LOW_CYC - 4'h1;
          state <= ST_WLOW;
        end
        ST_WLOW: begin
          if (tmr == 4'h0) begin
            pins.we_n <= 1'b1;
            tmr <= `FFPS_WE_HIGH_CYC - 4'h1;
            state <= ST_WHIGH;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        ST_WHIGH: begin
          if (tmr != 4'h0) begin
            tmr <= tmr - 4'h1;
          end else if (step != last && special == SP_NONE) begin
            step <= step + 10'd1;
            state <= ST_WSET;
          end else begin
            special <= SP_NONE;
            second <= 1'b0;
            if (special == SP_SUSP) begin
              SUSPENDED_O <= 1'b1;
              state <= ST_SUSP;
            end else if (op == OP_RST || op == OP_ABR) begin
              state <= ST_DONE;
            end else begin
              // one extra count: oe is only seen low from the next edge
              tmr <= `FFPS_READ_CYC;
              state <= ST_RLOW;
            end
          end
        end
        ST_RLOW: begin
          pins.a <= byte_mode ? base[23:1] : base[22:0];
          pins.dq <= {byte_mode & base[0], 15'h0000};
          pins.dq_oe <= {byte_mode, 15'h0000};
          pins.ce_n <= 1'b0;
          pins.oe_n <= 1'b0;
          if (tmr == 4'h0) begin
            rd <= FL_DQ_I;
            pins.oe_n <= 1'b1;
            state <= ST_EVAL;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        ST_EVAL: begin
          tmr <= `FFPS_READ_CYC;
          state <= ST_RLOW;
          if (op == OP_READ) begin
            RDATA_O <= rd;
            state <= ST_DONE;
          end else if (rd[`FFPS_POLL_BIT] == exp7) begin
            state <= ST_DONE;
          end else if (op == OP_BUF && rd[`FFPS_ABORT_BIT]) begin
            // abort seen: clear it with the abort-and-reset writes
            RESULT_O <= RES_ABORT;
            op <= OP_ABR;
            step <= 10'd0;
            last <= `FFPS_ABR_LAST;
            state <= ST_WSET;
          end else if (second) begin
            // bit 7 still wrong after the error bit: program failed
            RESULT_O <= RES_FAIL;
            op <= OP_RST;
            step <= 10'd0;
            last <= 10'd0;
            state <= ST_WSET;
          end else if (rd[`FFPS_ERROR_BIT]) begin
            second <= 1'b1;
          end else if (op == OP_BUF && SUSPEND_I) begin
            special <= SP_SUSP;
            state <= ST_WSET;
          end
        end
        ST_SUSP: begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 16'h0000;
          if (!SUSPEND_I) begin
            SUSPENDED_O <= 1'b0;
            special <= SP_RES;
            state <= ST_WSET;
          end
        end
        ST_DONE: begin
          pins.ce_n <= 1'b1;
          pins.dq_oe <= 16'h0000;
          DONE_O <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // flash pins straight from the pin register
  assign FL_A_O = pins.a;
  assign FL_DQ_O = pins.dq;
  assign FL_DQ_OE_O = pins.dq_oe;
  assign FL_CE_N_O = pins.ce_n;
  assign FL_OE_N_O = pins.oe_n;
  assign FL_WE_N_O = pins.we_n;
endmodule
`default_nettype wire

/* File: tb/ffps_chk.sv */
// port assertions for the fast program sequencer
`timescale 1ns/100ps
`default_nettype none
module ffps_chk import ffps_pkg::*; (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CMD_VALID_I,
  input wire ffps_cmd_t CMD_I,
  input wire logic BYTE_MODE_I,
  input wire logic CMD_READY_O,
  input wire logic WDATA_ACK_O,
  input wire logic DONE_O,
  input wire ffps_res_t RESULT_O,
  input wire logic [15:0] FL_DQ_OE_O,
  input wire logic FL_CE_N_O,
  input wire logic FL_OE_N_O,
  input wire logic FL_WE_N_O,
  input wire logic FL_BYTE_N_O,
  input wire logic FL_ACCEL_O
);
  // ----------------------------------------
  // command capture
  // ----------------------------------------
  ffps_op_t op_q;
  logic byte_q;
  logic take;
  logic over;
  assign take = CMD_READY_O && CMD_VALID_I;
  // page end is 255 words or 511 bytes from the page start
  assign over = BYTE_MODE_I ?
    ({1'b0, CMD_I.addr[8:0]} + 10'(CMD_I.count)) > 10'h1ff :
    ({2'b00, CMD_I.addr[7:0]} + 10'(CMD_I.count)) > 10'h0ff;
  // op and width of the command in flight
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      op_q <= OP_READ;
      byte_q <= 1'b0;
    end else if (take) begin
      op_q <= CMD_I.op;
      byte_q <= BYTE_MODE_I;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ready_drop_a: assert property (take |=> !CMD_READY_O)
    else $error("ready stayed high after a take");
  oct_refuse_a: assert property (
    take && CMD_I.op == OP_OCT && !BYTE_MODE_I |->
    FL_CE_N_O ##[1:2] (DONE_O && RESULT_O == RES_REFUSED))
    else $error("word wide octuple program not refused");
  page_refuse_a: assert property (
    take && CMD_I.op == OP_BUF && over |->
    ##[1:2] (DONE_O && RESULT_O == RES_REFUSED && FL_CE_N_O))
    else $error("page crossing run not refused");
  accel_buf_a: assert property (FL_ACCEL_O |-> op_q == OP_BUF)
    else $error("accel voltage outside buffered program");
  accel_off_a: assert property (DONE_O |=> !FL_ACCEL_O)
    else $error("accel voltage left on after done");
  we_low_a: assert property ($fell(FL_WE_N_O) |-> !FL_WE_N_O[*2])
    else $error("write strobe low too short");
  we_high_a: assert property ($rose(FL_WE_N_O) |-> FL_WE_N_O[*2])
    else $error("write strobe high too short");
  we_frame_a: assert property (!FL_WE_N_O |->
    !FL_CE_N_O && FL_OE_N_O && FL_DQ_OE_O == 16'hffff)
    else $error("write cycle without select or data drive");
  oe_read_a: assert property (!FL_OE_N_O |->
    FL_WE_N_O && FL_DQ_OE_O[14:0] == 15'h0000)
    else $error("read cycle while driving data");
  byte_pin_a: assert property (!FL_CE_N_O |-> FL_BYTE_N_O == !byte_q)
    else $error("width pin disagrees with command");
  done_ready_a: assert property (DONE_O |=> CMD_READY_O && !DONE_O)
    else $error("done not a pulse or ready not back");
  ack_pulse_a: assert property (WDATA_ACK_O |=> !WDATA_ACK_O)
    else $error("load ack longer than one cycle");
  cover property (take && CMD_I.op == OP_BUF);
  cover property (DONE_O && RESULT_O == RES_ABORT);
  cover property (DONE_O && RESULT_O == RES_FAIL);
endmodule
bind ffps_ctrl ffps_chk u_ffps_chk (.CLK_SYS_I, .NRST_I, .CMD_VALID_I,
  .CMD_I, .BYTE_MODE_I, .CMD_READY_O, .WDATA_ACK_O, .DONE_O, .RESULT_O,
  .FL_DQ_OE_O, .FL_CE_N_O, .FL_OE_N_O, .FL_WE_N_O, .FL_BYTE_N_O, .FL_ACCEL_O);
`default_nettype wire

/* File: tb/ffps_flash.sv */
// behavioural nor flash answering the sequencer pins
`timescale 1ns/100ps
`default_nettype none
module ffps_flash (
  input wire logic clk_i,
  input wire logic [22:0] a_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic byte_n_i,
  input wire logic [1:0] err_i,
  output logic [15:0] dq_o,
  output logic wr_o,
  output logic [23:0] wr_a_o,
  output logic [7:0] wr_d_o
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic tog = 1'b0;
  logic [1:0] busy = 2'd0;
  logic [1:0] errst = 2'd0;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  logic [15:0] mem [4096];
  logic st;
  logic code;
  assign st = we_n_i && !we_q && !ce_n_i;
  assign code = dq_i[7:0] inside {8'haa, 8'h55, 8'hf0, 8'hb0};
  initial for (int i = 0; i < 4096; i++) mem[i] = 16'hffff;
  // writes land at the rising strobe, status polls count down busy
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    oe_q <= oe_n_i;
    last <= dq_o;
    wr_o <= st;
    wr_a_o <= byte_n_i ? {1'b0, a_i} : {a_i, dq_i[15]};
    wr_d_o <= dq_i[7:0];
    if (st && dq_i[7:0] == 8'hf0) begin
      busy <= 2'd0;
      errst <= 2'd0;
    end else if (st && !code) begin
      busy <= 2'd3;
      errst <= err_i;
      mem[a_i[11:0]] <= mem[a_i[11:0]] & dq_i;
    end else if (oe_n_i && !oe_q) begin
      tog <= !tog;
      if (busy != 2'd0 && errst == 2'd0)
        busy <= busy - 2'd1;
    end
  end
  // status replaces array data while busy or failed
  always_comb begin
    rd = mem[a_i[11:0]];
    if (busy != 2'd0 || errst != 2'd0)
      rd = {8'h00, 1'b1, tog, errst == 2'd1, 3'b000, errst == 2'd2, 1'b0};
  end
  // released bus flips every cycle so a stale value never passes
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule
`default_nettype wire

/* File: tb/test_flash_fast_program_sequencer.sv */
// self-checking bench for the fast program sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ffps_regs.svh"
module test_flash_fast_program_sequencer import ffps_pkg::*;;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic CLK_SYS_I = 1'b0;
  logic NRST_I = 1'b0;
  logic CMD_VALID_I = 1'b0;
  ffps_cmd_t CMD_I = '0;
  logic BYTE_MODE_I = 1'b0;
  logic ACCEL_I = 1'b0;
  logic SUSPEND_I = 1'b0;
  logic WDATA_VALID_I = 1'b0;
  logic [15:0] WDATA_I = 16'h0000;
  logic [15:0] FL_DQ_I, RDATA_O, FL_DQ_O, FL_DQ_OE_O, fl_dq;
  logic CMD_READY_O, WDATA_ACK_O, DONE_O, SUSPENDED_O;
  ffps_res_t RESULT_O;
  logic [22:0] FL_A_O;
  logic FL_CE_N_O, FL_OE_N_O, FL_WE_N_O, FL_BYTE_N_O, FL_ACCEL_O;
  logic [1:0] err = 2'd0;
  logic wr, acc;
  logic [23:0] wr_a;
  logic [7:0] wr_d;
  logic [32:0] wq[$];
  logic [32:0] e;
  logic [18:0] rq[$];
  logic [18:0] r;
  logic [31:0] rnd = 32'h784f;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  ffps_op_t gop[4] = '{OP_DBL, OP_QUAD, OP_OCT, OP_QUAD};
  // each dq bit resolved from both drivers
  assign FL_DQ_I = (FL_DQ_OE_O & FL_DQ_O) | (~FL_DQ_OE_O & fl_dq);
  ffps_ctrl u_ffps_ctrl (.CLK_SYS_I, .NRST_I, .CMD_VALID_I, .CMD_I,
    .BYTE_MODE_I, .ACCEL_I, .SUSPEND_I, .WDATA_VALID_I, .WDATA_I, .FL_DQ_I,
    .CMD_READY_O, .WDATA_ACK_O, .DONE_O, .RESULT_O, .RDATA_O, .SUSPENDED_O,
    .FL_A_O, .FL_DQ_O, .FL_DQ_OE_O, .FL_CE_N_O, .FL_OE_N_O, .FL_WE_N_O,
    .FL_BYTE_N_O, .FL_ACCEL_O);
  ffps_flash u_ffps_flash (.clk_i(CLK_SYS_I), .a_i(FL_A_O), .dq_i(FL_DQ_I),
    .ce_n_i(FL_CE_N_O), .oe_n_i(FL_OE_N_O), .we_n_i(FL_WE_N_O),
    .byte_n_i(FL_BYTE_N_O), .err_i(err), .dq_o(fl_dq), .wr_o(wr),
    .wr_a_o(wr_a), .wr_d_o(wr_d));
  initial forever #10 CLK_SYS_I = ~CLK_SYS_I;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // care flag clear means the address is a don't care
  task automatic pw(input logic c, input logic [23:0] a, input logic [7:0] d);
    wq.push_back({c, a, d});
  endtask
  task automatic unl(input logic bm);
    pw(1'b1, bm ? `FFPS_UNLK1_X8 : `FFPS_UNLK1_X16, `FFPS_CODE_UNLK1);
    pw(1'b1, bm ? `FFPS_UNLK2_X8 : `FFPS_UNLK2_X16, `FFPS_CODE_UNLK2);
  endtask
  // one command with its loads; fl is {byte, accel, suspend}
  task automatic run(input ffps_op_t op, input logic [23:0] ad,
    input logic [7:0] n, input logic [2:0] fl, input ffps_res_t res);
    int k;
    int lds;
    logic [23:0] m;
    m = op == OP_DBL ? `FFPS_GRP_DBL_MSK :
      op == OP_QUAD ? `FFPS_GRP_QUAD_MSK : `FFPS_GRP_OCT_MSK;
    lds = op == OP_BUF ? int'(n) + 1 : op == OP_DBL ? 2 :
      op == OP_QUAD ? 4 : op == OP_OCT ? 8 : 0;
    if (res == RES_REFUSED)
      lds = 0;
    acc = fl[1] && op == OP_BUF;
    rq.push_back({op == OP_READ, res, 16'hffff});
    if (res != RES_REFUSED && (op == OP_BUF || op == OP_ABR))
      unl(fl[2]);
    if (lds > 0 && op == OP_BUF) begin
      pw(1'b1, ad, u_ffps_ctrl.BUF_SETUP);
      pw(1'b1, ad, n);
    end
    if (lds > 0 && op != OP_BUF)
      pw(1'b1, ad, op == OP_DBL ? u_ffps_ctrl.DBL_SETUP : op == OP_QUAD ?
        u_ffps_ctrl.QUAD_SETUP : u_ffps_ctrl.OCT_SETUP);
    if (op == OP_RST)
      pw(1'b0, ad, `FFPS_CODE_RESET);
    if (op == OP_ABR)
      pw(1'b0, ad, u_ffps_ctrl.ABORT_RESET);
    @(posedge CLK_SYS_I);
    CMD_I <= '{op, ad, n};
    {BYTE_MODE_I, ACCEL_I, SUSPEND_I} <= fl;
    CMD_VALID_I <= 1'b1;
    do @(posedge CLK_SYS_I); while (CMD_READY_O !== 1'b1);
    CMD_VALID_I <= 1'b0;
    // bit 7 of loads kept low so the polling compare is known
    for (k = 0; k < lds; k++) begin
      rnd = lfsr(rnd);
      pw(1'b1, op == OP_BUF ? ad + 24'(k) : (ad & ~m) | 24'(k),
        rnd[7:0] & 8'h7f);
      WDATA_I <= rnd[15:0] & 16'hff7f;
      WDATA_VALID_I <= 1'b1;
      do @(posedge CLK_SYS_I); while (WDATA_ACK_O !== 1'b1);
    end
    WDATA_VALID_I <= 1'b0;
    if (lds > 0 && op == OP_BUF)
      pw(1'b1, ad, u_ffps_ctrl.BUF_CONFIRM);
    if (fl[0]) begin
      pw(1'b0, ad, `FFPS_CODE_SUSPEND);
      pw(1'b0, ad, `FFPS_CODE_RESUME);
    end
    if (res == RES_FAIL)
      pw(1'b0, ad, `FFPS_CODE_RESET);
    if (res == RES_ABORT) begin
      unl(fl[2]);
      pw(1'b0, ad, u_ffps_ctrl.ABORT_RESET);
    end
    for (k = 0; k < 500 && fl[0] && SUSPENDED_O !== 1'b1; k++)
      @(posedge CLK_SYS_I);
    if (fl[0])
      chk(33'(SUSPENDED_O), 33'h1);
    SUSPEND_I <= 1'b0;
    for (k = 0; k < 3000 && DONE_O !== 1'b1; k++)
      @(posedge CLK_SYS_I);
    $display("test %s at %h done", op.name(), ad);
  endtask
  // ----------------------------------------
  // monitors and main sequence
  // ----------------------------------------
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (wr === 1'b1) begin
      e = wq.pop_front();
      chk({e[32] ? wr_a : e[31:8], wr_d, FL_ACCEL_O}, {e[31:0], acc});
    end
    if (DONE_O === 1'b1) begin
      r = rq.pop_front();
      chk({15'h0, RESULT_O, r[18] ? RDATA_O : r[15:0]}, {15'h0, r[17:0]});
    end
    if (cyc == 30000) begin
      chk(33'h0, 33'h1);
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge CLK_SYS_I);
    NRST_I <= 1'b1;
    run(OP_READ, 24'h000123, 8'h00, 3'b000, RES_OK);
    run(OP_RST, 24'h000000, 8'h00, 3'b000, RES_OK);
    run(OP_ABR, 24'h000000, 8'h00, 3'b000, RES_OK);
    foreach (gop[i])
      run(gop[i], 24'h00a5a5 + 24'(i), 8'h00, {i > 1, 2'b00}, RES_OK);
    run(OP_OCT, 24'h000040, 8'h00, 3'b000, RES_REFUSED);
    run(OP_BUF, 24'h0004fd, 8'h02, 3'b010, RES_OK);
    run(OP_BUF, 24'h0004fe, 8'h02, 3'b000, RES_REFUSED);
    run(OP_BUF, 24'h0003fc, 8'h03, 3'b100, RES_OK);
    run(OP_BUF, 24'h0003fc, 8'h04, 3'b100, RES_REFUSED);
    run(OP_BUF, 24'h000600, 8'hff, 3'b000, RES_OK);
    run(OP_BUF, 24'h000810, 8'h01, 3'b001, RES_OK);
    err <= 2'd1;
    run(OP_QUAD, 24'h000900, 8'h00, 3'b000, RES_FAIL);
    err <= 2'd2;
    run(OP_BUF, 24'h000a00, 8'h01, 3'b000, RES_ABORT);
    err <= 2'd0;
    run(OP_READ, 24'h000124, 8'h00, 3'b000, RES_OK);
    repeat (4) @(posedge CLK_SYS_I);
    chk(33'(wq.size() + rq.size()), 33'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
